// >>> verilog/ecc_irq_pkg.sv
// What this block does
// - With the debug-unlock enable bit 0 set and the status lock indication high, raise an irq.
// - A flash ECC error sets bit 2 of the error flags; writing 1 clears it; reset 0.
// - A cache ECC error sets bit 1 of the error flags; writing 1 clears it; reset 0.
// - A RAM ECC error sets bit 0 of the error flags; writing 1 clears it; reset 0.
// - A flash correctable error sets bit 2 of the correctable flags; W1C; reset 0.
// - A cache correctable error sets bit 1 of the correctable flags; W1C; reset 0.
// - A RAM correctable error sets bit 0 of the correctable flags; W1C; reset 0.
// - Bit 2 of the ECC irq enable is a read/write flash enable, reset 0.
// - Bit 1 of the ECC irq enable is a read/write cache enable, reset 0.
// - Bit 0 of the ECC irq enable is a read/write RAM enable, reset 0.
package ecc_irq_pkg;
    localparam logic [7:0] sys_irq_en_off = 8'h54;
    localparam logic [7:0] err_flags_off = 8'h64;
    localparam logic [7:0] ced_flags_off = 8'h68;
    localparam logic [7:0] ecc_irq_en_off = 8'h6c;
    localparam int unlock_en_bit = 0;
    localparam int ram_bit = 0;
    localparam int cache_bit = 1;
    localparam int flash_bit = 2;
    localparam int src_count = 3;
    localparam logic [2:0] flags_reset = 3'h0;
    localparam logic unlock_en_reset = 1'b0;
endpackage : ecc_irq_pkg

// >>> verilog/w1c_flags_if.sv
`timescale 1ns/100ps
interface w1c_flags_if;
    logic [2:0] set_evt;
    logic [2:0] clr;
    logic [2:0] flags;
    modport owner (input set_evt, input clr, output flags);
    modport user (output set_evt, output clr, input flags);
endinterface : w1c_flags_if

// >>> verilog/w1c_flags.sv
`timescale 1ns/100ps
module w1c_flags
    import ecc_irq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // flag access
    w1c_flags_if.owner fl
);
    logic [2:0] flags_reg;
    logic [2:0] flags_next;

    always_comb begin
        // set wins over clear
        flags_next = (flags_reg & ~fl.clr) | fl.set_evt;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= flags_reset;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign fl.flags = flags_reg;

    set_wins_a: assert property (@(posedge mclk) disable iff (!rst_n)
        |fl.set_evt |=> ((flags_reg & $past(fl.set_evt)) == $past(fl.set_evt)))
        else $error("event lost");
    clear_works_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (|(fl.clr & ~fl.set_evt)) |=> ((flags_reg & $past(fl.clr & ~fl.set_evt)) == 3'h0))
        else $error("flag not cleared");
    hold_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (fl.clr == 3'h0) |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
        else $error("flag lost without clear");
endmodule : w1c_flags

// >>> verilog/ecc_irq_ctrl.sv
// Added by the designer: register access over Wishbone.
`timescale 1ns/100ps
module ecc_irq_ctrl
    import ecc_irq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // ecc events, one bit per source
    input wire logic [2:0] ecc_err_evt,
    input wire logic [2:0] ecc_ced_evt,
    // lock indication
    input wire logic status_lock,
    // interrupts
    output logic ecc_irq,
    output logic unlock_irq
);
    // =========================================
    // reset synchroniser
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // =========================================
    // bus decode
    logic req;
    logic wr_ok;
    logic hit;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign hit = (wb_adr_i == sys_irq_en_off) || (wb_adr_i == err_flags_off) ||
                 (wb_adr_i == ced_flags_off) || (wb_adr_i == ecc_irq_en_off);
    assign wr_ok = req & hit & wb_we_i & wb_sel_i[0];

    // =========================================
    // sticky flags
    w1c_flags_if err_if ();
    w1c_flags_if ced_if ();

    assign err_if.set_evt = ecc_err_evt;
    assign ced_if.set_evt = ecc_ced_evt;
    // only ones clear; zeros leave the flag
    assign err_if.clr = (wr_ok && wb_adr_i == err_flags_off) ? wb_dat_i[2:0] : 3'h0;
    assign ced_if.clr = (wr_ok && wb_adr_i == ced_flags_off) ? wb_dat_i[2:0] : 3'h0;

    w1c_flags err_flags_u (
        .mclk(mclk),
        .rst_n(rst_n),
        .fl(err_if.owner)
    );
    w1c_flags ced_flags_u (
        .mclk(mclk),
        .rst_n(rst_n),
        .fl(ced_if.owner)
    );

    // =========================================
    // control registers and bus answer
    logic unlock_en_reg;
    logic unlock_en_next;
    logic [2:0] ecc_en_reg;
    logic [2:0] ecc_en_next;
    logic ack_reg;
    logic ack_next;
    logic err_reg;
    logic err_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic ecc_irq_reg;
    logic ecc_irq_next;
    logic unlock_irq_reg;
    logic unlock_irq_next;

    always_comb begin
        unlock_en_next = unlock_en_reg;
        ecc_en_next = ecc_en_reg;
        if (wr_ok && wb_adr_i == sys_irq_en_off) begin
            unlock_en_next = wb_dat_i[unlock_en_bit];
        end
        if (wr_ok && wb_adr_i == ecc_irq_en_off) begin
            ecc_en_next = wb_dat_i[2:0];
        end
        ack_next = req & hit;
        err_next = req & ~hit;
        rdata_next = 32'h0000_0000;
        if (req && hit && !wb_we_i) begin
            case (wb_adr_i)
                sys_irq_en_off: rdata_next = {31'h0000_0000, unlock_en_reg};
                err_flags_off: rdata_next = {29'h0000_0000, err_if.flags};
                ced_flags_off: rdata_next = {29'h0000_0000, ced_if.flags};
                ecc_irq_en_off: rdata_next = {29'h0000_0000, ecc_en_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        ecc_irq_next = |(err_if.flags & ecc_en_reg);
        unlock_irq_next = unlock_en_reg & status_lock;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            unlock_en_reg <= unlock_en_reset;
            ecc_en_reg <= flags_reset;
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            ecc_irq_reg <= 1'b0;
            unlock_irq_reg <= 1'b0;
        end else begin
            unlock_en_reg <= unlock_en_next;
            ecc_en_reg <= ecc_en_next;
            ack_reg <= ack_next;
            err_reg <= err_next;
            rdata_reg <= rdata_next;
            ecc_irq_reg <= ecc_irq_next;
            unlock_irq_reg <= unlock_irq_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = rdata_reg;
    assign ecc_irq = ecc_irq_reg;
    assign unlock_irq = unlock_irq_reg;

    // =========================================
    // checks
    unlock_irq_a: assert property (@(posedge mclk) disable iff (!rst_n)
        unlock_irq == $past(unlock_en_reg & status_lock))
        else $error("unlock irq wrong");
    ecc_irq_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ecc_irq == $past(|(err_if.flags & ecc_en_reg)))
        else $error("ecc irq wrong");
    flash_err_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ecc_err_evt[flash_bit] |=> err_if.flags[flash_bit])
        else $error("flash error flag not set");
    cache_err_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ecc_err_evt[cache_bit] |=> err_if.flags[cache_bit])
        else $error("cache error flag not set");
    ram_err_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ecc_err_evt[ram_bit] |=> err_if.flags[ram_bit])
        else $error("ram error flag not set");
    flash_ced_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ecc_ced_evt[flash_bit] |=> ced_if.flags[flash_bit])
        else $error("flash correctable flag not set");
    cache_ced_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ecc_ced_evt[cache_bit] |=> ced_if.flags[cache_bit])
        else $error("cache correctable flag not set");
    ram_ced_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ecc_ced_evt[ram_bit] |=> ced_if.flags[ram_bit])
        else $error("ram correctable flag not set");
    enable_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_ok && wb_adr_i == ecc_irq_en_off) |=> ecc_en_reg == $past(wb_dat_i[2:0]))
        else $error("enable write lost");
    ack_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    err_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_err_o |=> !wb_err_o)
        else $error("err longer than one cycle");
    mapped_ack_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req && hit) |=> (wb_ack_o && !wb_err_o))
        else $error("mapped access not acked");
    unmapped_err_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req && !hit) |=> (wb_err_o && !wb_ack_o))
        else $error("unmapped access not refused");
    rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
        else $error("read data not zero while idle");
    unlock_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_ok && wb_adr_i == sys_irq_en_off) |=> unlock_en_reg == $past(wb_dat_i[0]))
        else $error("unlock enable write lost");
    sel_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (req && wb_we_i && !wb_sel_i[0]) |=> $stable(ecc_en_reg))
        else $error("write without lane 0 took effect");
endmodule : ecc_irq_ctrl

// >>> tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    import ecc_irq_pkg::*;
    logic mclk, reset_n, cyc, stb, we, ack, err, lock, ecc_irq, unlock_irq, last_err;
    logic [7:0] adr;
    logic [3:0] sel, sel_use;
    logic [31:0] wdat, rdat, q;
    logic [2:0] err_evt, ced_evt, b;
    int mismatches, n_checks;

    ecc_irq_ctrl uut (.mclk(mclk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .ecc_err_evt(err_evt), .ecc_ced_evt(ced_evt),
        .status_lock(lock), .ecc_irq(ecc_irq), .unlock_irq(unlock_irq));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ==========================================
    // bus and compare tasks
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // classic cycle: hold until ack or err, then release
    task access(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= sel_use;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
        q = rdat;
        last_err = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            end_of_test;
        end
    endtask : access

    task rd(input logic [7:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h0000_0000);
        chk(q, exp);
    endtask : rd

    task wr(input logic [7:0] a, input logic [31:0] d);
        access(1'b1, a, d);
    endtask : wr

    // ==========================================
    // main sequence
    initial begin
        {reset_n, cyc, stb, we, lock, last_err} = 6'b0;
        adr = 8'h00;
        sel = 4'h0;
        sel_use = 4'hf;
        wdat = 32'h0000_0000;
        err_evt = 3'h0;
        ced_evt = 3'h0;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(sys_irq_en_off, 32'h0000_0000);
        rd(err_flags_off, 32'h0000_0000);
        rd(ced_flags_off, 32'h0000_0000);
        rd(ecc_irq_en_off, 32'h0000_0000);
        rd(8'h70, 32'h0000_0000);
        chk({31'h0, last_err}, 32'h0000_0001);
        sel_use = 4'he;
        wr(ecc_irq_en_off, 32'hffff_ffff);
        sel_use = 4'hf;
        rd(ecc_irq_en_off, 32'h0000_0000);
        wr(ecc_irq_en_off, 32'hffff_ffff);
        rd(ecc_irq_en_off, 32'h0000_0007);
        wr(ecc_irq_en_off, 32'h0000_0000);
        $display("test reset and enables done");
        for (int i = 0; i < src_count; i++) begin
            b = 3'h1 << i;
            err_evt <= b;
            ced_evt <= b;
            @(posedge mclk);
            err_evt <= 3'h0;
            ced_evt <= 3'h0;
            rd(err_flags_off, {29'h0, b});
            rd(ced_flags_off, {29'h0, b});
            chk({31'h0, ecc_irq}, 32'h0000_0000);
            wr(ecc_irq_en_off, {29'h0, ~b});
            repeat (2) @(posedge mclk);
            chk({31'h0, ecc_irq}, 32'h0000_0000);
            wr(ecc_irq_en_off, {29'h0, b});
            repeat (2) @(posedge mclk);
            chk({31'h0, ecc_irq}, 32'h0000_0001);
            wr(err_flags_off, 32'h0000_0000);
            rd(err_flags_off, {29'h0, b});
            wr(err_flags_off, {29'h0, b});
            rd(err_flags_off, 32'h0000_0000);
            repeat (2) @(posedge mclk);
            chk({31'h0, ecc_irq}, 32'h0000_0000);
            wr(ced_flags_off, {29'h0, b});
            rd(ced_flags_off, 32'h0000_0000);
            wr(ecc_irq_en_off, 32'h0000_0000);
        end
        $display("test flags per source done");
        // event high only at the edge that takes the clear
        fork
            wr(err_flags_off, 32'h0000_0002);
            begin
                @(posedge mclk);
                err_evt <= 3'h2;
                @(posedge mclk);
                err_evt <= 3'h0;
            end
        join
        rd(err_flags_off, 32'h0000_0002);
        wr(err_flags_off, 32'h0000_0002);
        rd(err_flags_off, 32'h0000_0000);
        $display("test set against clear done");
        lock <= 1'b1;
        repeat (2) @(posedge mclk);
        chk({31'h0, unlock_irq}, 32'h0000_0000);
        wr(sys_irq_en_off, 32'hffff_ffff);
        rd(sys_irq_en_off, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        chk({31'h0, unlock_irq}, 32'h0000_0001);
        lock <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({31'h0, unlock_irq}, 32'h0000_0000);
        $display("test unlock interrupt done");
        end_of_test;
    end
endmodule : testbench
